// [hdl/bfl_handshake.v]
// bar feeder side of the lathe handshake: command edge capture, completion
// reply, end-of-bar timing, clamp reading, test-cycle gate, APB registers.
// assumes all lathe and sensor inputs are already synchronous to CLK.
//
// Functional notes
// R1 - feed-on-command waits for a lathe command
// R2 - reply at target, push while clamp open
// R3 - command feed off: clamp opening starts feeding
// R4 - command feed off: clamp closing stops feeding
// R5 - short timing: end-of-bar while short and closed
// R6 - long timing: clear on second reply edge
// R7 - standard timing: clear on ejection command edge
// R8 - clamp polarity setting selects open level
// R9 - pulse style: fixed half-second completion pulse
// R10 - level style: reply while command held, capped
// R11 - new command only on edge, not replying
// R12 - lathe leaves about 0.2 s between commands
// R13 - unseparable commands raise error code nine
// R14 - level style advised; pulse style may merge
// R15 - stroke set a few mm under travel
// R16 - keep material sensor distance for positioning
// R17 - channel offset accepted only 0 to 20
// R18 - no test cycle while cover open
// R19 - completion low outside acknowledgement window
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "bfl_consts.vh"

module bfl_handshake #(
  parameter [`BFL_TMR_W-1:0] ACK_CYCLES = `BFL_ACK_CYCLES,
  parameter [`BFL_TMR_W-1:0] GAP_CYCLES = `BFL_GAP_CYCLES
) (
  // clock and reset
  input wire CLK,
  input wire RST,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`BFL_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // lathe interface
  input wire MCODE,
  input wire CLAMP_IN,
  output reg MFIN,
  output reg EOB,
  // feeder sensors and motion
  input wire SHORT_BAR,
  input wire ACT_DONE,
  input wire BAR_REPLACE,
  input wire COVER_OPEN,
  output reg FEED,
  output reg TEST_RUN,
  output reg [`BFL_ERR_W-1:0] ERR_CODE,
  // length settings for the motion logic
  output reg [`BFL_LEN_W-1:0] STROKE_MM,
  output reg [`BFL_LEN_W-1:0] SENSOR_POS_MM,
  output reg [`BFL_CHOFS_W-1:0] CHAN_OFS_MM,
  // interrupt
  output wire IRQ
);

  // ****************************************
  // state codes
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_BUSY = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;

  reg [1:0] state_q, state_d;
  reg [`BFL_CTRL_W-1:0] ctrl_q;
  reg [`BFL_EV_W-1:0] sts_q, mask_q;
  reg mcode_prev_q, short_prev_q, mfin_prev_q;
  reg [`BFL_TMR_W-1:0] ack_tmr_q, gap_tmr_q;
  reg [1:0] rcnt_q;

  wire feed_cmd = ctrl_q[`BFL_B_FEED_CMD];
  wire [1:0] eob_mode = ctrl_q[`BFL_F_EOB_HI:`BFL_F_EOB_LO];
  wire static_ack = ctrl_q[`BFL_B_STATIC];

  // ****************************************
  // input interpretation
  // ****************************************
  wire clamp_open = CLAMP_IN ^ ctrl_q[`BFL_B_CLAMP_INV]; // R8
  wire mcode_rise = MCODE & ~mcode_prev_q;
  wire mcode_fall = ~MCODE & mcode_prev_q;
  wire short_rise = SHORT_BAR & ~short_prev_q;
  wire gap_run = (gap_tmr_q != {`BFL_TMR_W{1'b0}});
  // an edge during the reply cannot be told apart from the one being acked
  wire cmd_accept = mcode_rise & (state_q != ST_ACK); // R11
  wire cmd_clash = mcode_rise & ((state_q != ST_IDLE) | gap_run); // R13
  wire ack_expire = (ack_tmr_q == {`BFL_TMR_W{1'b0}});
  wire mfin_rise = MFIN & ~mfin_prev_q;

  // ****************************************
  // apb decode
  // ****************************************
  wire acc = PSEL & PENABLE;
  wire setup = PSEL & ~PENABLE;
  reg hit;
  always @* begin
    case (PADDR)
      `BFL_OFS_CTRL, `BFL_OFS_STATUS, `BFL_OFS_MASK, `BFL_OFS_STATE,
      `BFL_OFS_STROKE, `BFL_OFS_SENSOR, `BFL_OFS_CHOFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  wire wr = acc & PWRITE & hit;
  wire ofs_bad = (PADDR == `BFL_OFS_CHOFS) &&
                 (PWDATA[31:0] > {27'h000_0000, `BFL_CHOFS_MAX});
  // zero wait states: read data is captured during the setup cycle
  assign PREADY = 1'b1;
  assign PSLVERR = acc & (~hit | (PWRITE & ofs_bad));
  wire sts_rd = acc & ~PWRITE & (PADDR == `BFL_OFS_STATUS);

  // ****************************************
  // command / reply sequencer
  // ****************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_accept) begin
          state_d = ST_BUSY; // R1
        end
      end
      ST_BUSY: begin
        if (ACT_DONE) begin
          state_d = ST_ACK; // R2
        end
      end
      ST_ACK: begin
        if (ack_expire | (static_ack & ~MCODE)) begin
          state_d = ST_IDLE; // R10
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      ack_tmr_q <= {`BFL_TMR_W{1'b0}};
      gap_tmr_q <= {`BFL_TMR_W{1'b0}};
      mcode_prev_q <= 1'b0;
      short_prev_q <= 1'b0;
      mfin_prev_q <= 1'b0;
      MFIN <= 1'b0;
    end else begin
      state_q <= state_d;
      mcode_prev_q <= MCODE;
      short_prev_q <= SHORT_BAR;
      mfin_prev_q <= MFIN;
      if (state_q == ST_BUSY && ACT_DONE) begin
        ack_tmr_q <= ACK_CYCLES - {{(`BFL_TMR_W-1){1'b0}}, 1'b1};
      end else if (!ack_expire) begin
        ack_tmr_q <= ack_tmr_q - {{(`BFL_TMR_W-1){1'b0}}, 1'b1};
      end
      if (mcode_fall) begin
        gap_tmr_q <= GAP_CYCLES;
      end else if (gap_run) begin
        gap_tmr_q <= gap_tmr_q - {{(`BFL_TMR_W-1){1'b0}}, 1'b1};
      end
      // pulse style ignores the command level, level style follows it
      if (state_d == ST_ACK) begin
        MFIN <= static_ack ? MCODE : 1'b1; // R9 R10
      end else begin
        MFIN <= 1'b0; // R19
      end
    end
  end

  // ****************************************
  // feeding
  // ****************************************
  always @(posedge CLK) begin
    if (RST) begin
      FEED <= 1'b0;
    end else if (!feed_cmd) begin
      FEED <= clamp_open; // R3 R4
    end else if (cmd_accept && state_q == ST_IDLE) begin
      FEED <= 1'b1; // R1
    end else if (state_q != ST_BUSY && !clamp_open) begin
      // keeps pushing after the reply until the clamp shuts
      FEED <= 1'b0; // R2
    end
  end

  // ****************************************
  // end of bar
  // ****************************************
  always @(posedge CLK) begin
    if (RST || !BAR_REPLACE) begin
      rcnt_q <= `BFL_RCNT_EJECT;
    end else if (cmd_accept && rcnt_q != 2'h3) begin
      rcnt_q <= rcnt_q + 2'h1;
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      EOB <= 1'b0;
    end else begin
      case (eob_mode)
        `BFL_EOB_SHORT: EOB <= SHORT_BAR & ~clamp_open; // R5
        `BFL_EOB_LONG: begin
          if (short_rise) begin
            EOB <= 1'b1; // R6
          end else if (mfin_rise && rcnt_q == `BFL_RCNT_SECOND) begin
            EOB <= 1'b0; // R6
          end
        end
        `BFL_EOB_STD: begin
          if (short_rise) begin
            EOB <= 1'b1; // R7
          end else if (cmd_accept && BAR_REPLACE &&
                       rcnt_q == `BFL_RCNT_EJECT) begin
            EOB <= 1'b0; // R7
          end
        end
        default: EOB <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // error and test cycle
  // ****************************************
  wire test_refused = ctrl_q[`BFL_B_TEST] & COVER_OPEN;
  always @(posedge CLK) begin
    if (RST) begin
      ERR_CODE <= `BFL_ERR_NONE;
      TEST_RUN <= 1'b0;
    end else begin
      if (cmd_clash) begin
        ERR_CODE <= `BFL_ERR_MERGE; // R13
      end else if (wr && PADDR == `BFL_OFS_STATE) begin
        ERR_CODE <= `BFL_ERR_NONE;
      end
      TEST_RUN <= ctrl_q[`BFL_B_TEST] & ~COVER_OPEN; // R18
    end
  end

  // ****************************************
  // registers
  // ****************************************
  wire [`BFL_EV_W-1:0] ev;
  assign ev[`BFL_EV_CMD] = cmd_accept;
  assign ev[`BFL_EV_DONE] = mfin_rise;
  assign ev[`BFL_EV_EOB] = short_rise;
  assign ev[`BFL_EV_ERR] = cmd_clash;
  assign ev[`BFL_EV_TREF] = test_refused;

  always @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= `BFL_CTRL_RST;
      mask_q <= {`BFL_EV_W{1'b0}};
      sts_q <= {`BFL_EV_W{1'b0}};
      STROKE_MM <= `BFL_STROKE_RST;
      SENSOR_POS_MM <= `BFL_SENSOR_RST; // R16
      CHAN_OFS_MM <= `BFL_CHOFS_RST;
    end else begin
      // an event in the clearing read's cycle survives the clear
      sts_q <= (sts_q & ~{`BFL_EV_W{sts_rd}}) | ev;
      if (wr) begin
        case (PADDR)
          `BFL_OFS_CTRL: ctrl_q <= PWDATA[`BFL_CTRL_W-1:0];
          `BFL_OFS_MASK: mask_q <= PWDATA[`BFL_EV_W-1:0];
          `BFL_OFS_STROKE: STROKE_MM <= PWDATA[`BFL_LEN_W-1:0]; // R15
          `BFL_OFS_SENSOR: SENSOR_POS_MM <= PWDATA[`BFL_LEN_W-1:0]; // R16
          `BFL_OFS_CHOFS: begin
            if (!ofs_bad) begin
              CHAN_OFS_MM <= PWDATA[`BFL_CHOFS_W-1:0]; // R17
            end
          end
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup) begin
      case (PADDR)
        `BFL_OFS_CTRL: PRDATA <= {26'h000_0000, ctrl_q};
        `BFL_OFS_STATUS: PRDATA <= {27'h000_0000, sts_q};
        `BFL_OFS_MASK: PRDATA <= {27'h000_0000, mask_q};
        `BFL_OFS_STATE: PRDATA <= {20'h0_0000, ERR_CODE, 1'b0,
          state_q, TEST_RUN, clamp_open, EOB, MFIN, FEED};
        `BFL_OFS_STROKE: PRDATA <= {20'h0_0000, STROKE_MM};
        `BFL_OFS_SENSOR: PRDATA <= {20'h0_0000, SENSOR_POS_MM};
        `BFL_OFS_CHOFS: PRDATA <= {27'h000_0000, CHAN_OFS_MM};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  assign IRQ = |(sts_q & mask_q);

endmodule

// [hdl/bfl_consts.vh]
// constants for the bar feeder / lathe handshake block
// assumes a 250 MHz controller clock and a 32-bit APB register bus
`ifndef BFL_CONSTS_VH
`define BFL_CONSTS_VH

// ****************************************
// clock and timing
// ****************************************
`define BFL_CLK_MHZ 250
`define BFL_ACK_TIME_MS 500
`define BFL_GAP_TIME_MS 200
`define BFL_ACK_CYCLES (`BFL_ACK_TIME_MS * 1000 * `BFL_CLK_MHZ)
`define BFL_GAP_CYCLES (`BFL_GAP_TIME_MS * 1000 * `BFL_CLK_MHZ)
`define BFL_TMR_W 28

// ****************************************
// register byte addresses
// ****************************************
`define BFL_ADDR_W 8
`define BFL_OFS_CTRL 8'h00
`define BFL_OFS_STATUS 8'h04
`define BFL_OFS_MASK 8'h08
`define BFL_OFS_STATE 8'h0C
`define BFL_OFS_STROKE 8'h10
`define BFL_OFS_SENSOR 8'h14
`define BFL_OFS_CHOFS 8'h18

// ****************************************
// control fields and reset values
// ****************************************
`define BFL_CTRL_W 6
`define BFL_CTRL_RST 6'h11
`define BFL_B_FEED_CMD 0
`define BFL_F_EOB_LO 1
`define BFL_F_EOB_HI 2
`define BFL_B_CLAMP_INV 3
`define BFL_B_STATIC 4
`define BFL_B_TEST 5

`define BFL_EOB_SHORT 2'h0
`define BFL_EOB_LONG 2'h1
`define BFL_EOB_STD 2'h2

// ****************************************
// event bits (status and mask)
// ****************************************
`define BFL_EV_W 5
`define BFL_EV_CMD 0
`define BFL_EV_DONE 1
`define BFL_EV_EOB 2
`define BFL_EV_ERR 3
`define BFL_EV_TREF 4

// ****************************************
// length settings in mm
// ****************************************
`define BFL_LEN_W 12
`define BFL_STROKE_RST 12'h06D6
`define BFL_SENSOR_RST 12'h0692
`define BFL_CHOFS_W 5
`define BFL_CHOFS_RST 5'h0A
`define BFL_CHOFS_MAX 5'h14

// ****************************************
// error codes and misc
// ****************************************
`define BFL_ERR_W 4
`define BFL_ERR_NONE 4'h0
`define BFL_ERR_MERGE 4'h9
`define BFL_RCNT_EJECT 2'h0
`define BFL_RCNT_SECOND 2'h2

`endif

// [tb/bfl_assertions.sv]
// checker for the bar feeder handshake block
// assumes it is bound to the block top; one clock domain
`timescale 1ns/1ps
module bfl_assertions #(
  parameter [27:0] ACK_CYCLES = 28'h000_0014
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // lathe, feeder and settings
  input wire logic MCODE,
  input wire logic ACT_DONE,
  input wire logic COVER_OPEN,
  input wire logic MFIN,
  input wire logic TEST_RUN,
  input wire logic [3:0] ERR_CODE,
  input wire logic [4:0] CHAN_OFS_MM
);
  // ****
  // reply length counter
  // ****
  logic [27:0] mf_q;
  always @(posedge CLK)
    if (RST)
      mf_q <= 28'h000_0000;
    else
      mf_q <= MFIN ? mf_q + 28'h000_0001 : 28'h000_0000;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  property p_test; TEST_RUN |-> !$past(COVER_OPEN); endproperty
  a_test: assert property (p_test) else $error("test with cover open");
  property p_code; ERR_CODE == 4'h0 || ERR_CODE == 4'h9; endproperty
  a_code: assert property (p_code) else $error("bad error code");
  property p_chofs; CHAN_OFS_MM <= 5'h14; endproperty
  a_chofs: assert property (p_chofs) else $error("offset too big");
  property p_len; MFIN |-> mf_q < ACK_CYCLES; endproperty
  a_len: assert property (p_len) else $error("reply too long");
  property p_rise; $rose(MFIN) |-> $past(ACT_DONE); endproperty
  a_rise: assert property (p_rise) else $error("reply not done");
  property p_clash; $rose(MCODE) && MFIN |=> ##[0:1] ERR_CODE == 4'h9;
  endproperty
  a_clash: assert property (p_clash) else $error("no clash code");
  property p_gap; $fell(MFIN) |=> !MFIN; endproperty
  a_gap: assert property (p_gap) else $error("reply restarted");
  property p_why; $changed(ERR_CODE) && ERR_CODE == 4'h9 |-> $past(MCODE);
  endproperty
  a_why: assert property (p_why) else $error("error without cmd");
endmodule

// [tb/bfl_lathe_model.sv]
// lathe side model: command level and clamp signal
// assumes calls start just after a rising clock edge
`timescale 1ns/1ps
module bfl_lathe_model #(
  parameter int GAP = 8
) (
  // clock
  input wire logic clk,
  // handshake
  input wire logic mfin,
  output logic mcode,
  output logic clamp
);
  initial begin
    mcode = 1'b0;
    clamp = 1'b0;
  end
  task automatic clampv(input bit v);
    @(posedge clk) clamp <= v;
  endtask
  // held command drops on reply; pulsed one ignores it
  task automatic cmd(input bit hold, input int pw);
    int n;
    n = 0;
    @(posedge clk) mcode <= 1'b1;
    while (hold && mfin !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (!hold)
      repeat (pw) @(posedge clk);
    mcode <= 1'b0;
    repeat (GAP + 2) @(posedge clk);
  endtask
endmodule

// [tb/tb_top.sv]
// testbench for the bar feeder handshake block
// assumes the lathe model and checker are compiled first
`timescale 1ns/1ps
`include "bfl_consts.vh"
module tb_top;
  logic CLK = 0, RST = 1, sv;
  logic PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, q;
  logic SHORT_BAR = 0, ACT_DONE = 1, BAR_REPLACE = 0, COVER_OPEN = 0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, MCODE, CLAMP_IN, MFIN, EOB, FEED, TEST_RUN, IRQ;
  wire [3:0] ERR_CODE;
  wire [11:0] STROKE_MM, SENSOR_POS_MM;
  wire [4:0] CHAN_OFS_MM;
  int n_fail = 0, checks = 0, n;
  bfl_handshake #(.ACK_CYCLES(28'h000_0014), .GAP_CYCLES(28'h000_0008)) dut (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MCODE(MCODE), .CLAMP_IN(CLAMP_IN), .MFIN(MFIN),
    .EOB(EOB), .SHORT_BAR(SHORT_BAR), .ACT_DONE(ACT_DONE),
    .BAR_REPLACE(BAR_REPLACE), .COVER_OPEN(COVER_OPEN), .FEED(FEED),
    .TEST_RUN(TEST_RUN), .ERR_CODE(ERR_CODE), .STROKE_MM(STROKE_MM),
    .SENSOR_POS_MM(SENSOR_POS_MM), .CHAN_OFS_MM(CHAN_OFS_MM), .IRQ(IRQ));
  bfl_lathe_model lathe (.clk(CLK), .mfin(MFIN),
    .mcode(MCODE), .clamp(CLAMP_IN));
  initial forever #2 CLK = ~CLK;
  task automatic w(input int c);
    repeat (c) @(posedge CLK);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    q = PRDATA;
    sv = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic meas(output int c);
    int k;
    c = 0;
    k = 0;
    while (MFIN !== 1'b1 && k < 100) begin
      @(posedge CLK);
      k++;
    end
    while (MFIN === 1'b1 && c < 100) begin
      @(posedge CLK);
      c++;
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    w(16);
    RST <= 0;
    rdc(`BFL_OFS_CTRL, 32'h0000_0011);
    rdc(`BFL_OFS_STROKE, 32'h0000_06D6);
    rdc(`BFL_OFS_SENSOR, 32'h0000_0692);
    rdc(`BFL_OFS_CHOFS, 32'h0000_000A);
    chk(STROKE_MM, 32'h0000_06D6);
    chk(SENSOR_POS_MM, 32'h0000_0692);
    chk(CHAN_OFS_MM, 32'h0000_000A);
    apb(1, `BFL_OFS_CHOFS, 32'h0000_0015);
    chk(sv, 1);
    rdc(`BFL_OFS_CHOFS, 32'h0000_000A);
    apb(1, `BFL_OFS_CHOFS, 32'h0000_0014);
    rdc(`BFL_OFS_CHOFS, 32'h0000_0014);
    chk(CHAN_OFS_MM, 32'h0000_0014);
    rdc(8'h40, 32'h0000_0000);
    chk(sv, 1);
    lathe.clampv(1);
    w(2);
    chk(FEED, 0);
    ACT_DONE <= 0;
    fork
      lathe.cmd(1, 0);
      begin
        w(6);
        chk(FEED, 1);
        chk(MFIN, 0);
        ACT_DONE <= 1;
      end
    join
    chk(MFIN, 0);
    chk(FEED, 1);
    chk(IRQ, 0);
    apb(1, `BFL_OFS_MASK, 32'h0000_0001);
    w(1);
    chk(IRQ, 1);
    rdc(`BFL_OFS_STATUS, 32'h0000_0003);
    w(1);
    chk(IRQ, 0);
    lathe.clampv(0);
    w(3);
    chk(FEED, 0);
    apb(1, `BFL_OFS_CTRL, 32'h0000_0001);
    fork
      lathe.cmd(0, 2);
      meas(n);
    join
    chk(n, 20);
    lathe.cmd(0, 2);
    lathe.cmd(0, 2);
    w(30);
    chk(ERR_CODE, 9);
    apb(1, `BFL_OFS_STATE, 32'h0000_0000);
    w(1);
    chk(ERR_CODE, 0);
    apb(1, `BFL_OFS_CTRL, 32'h0000_0010);
    lathe.clampv(1);
    w(2);
    chk(FEED, 1);
    lathe.clampv(0);
    w(2);
    chk(FEED, 0);
    apb(1, `BFL_OFS_CTRL, 32'h0000_0018);
    w(2);
    chk(FEED, 1);
    apb(1, `BFL_OFS_CTRL, 32'h0000_0011);
    SHORT_BAR <= 1;
    w(2);
    chk(EOB, 1);
    lathe.clampv(1);
    w(2);
    chk(EOB, 0);
    lathe.clampv(0);
    SHORT_BAR <= 0;
    apb(1, `BFL_OFS_CTRL, 32'h0000_0015);
    SHORT_BAR <= 1;
    w(2);
    chk(EOB, 1);
    BAR_REPLACE <= 1;
    lathe.cmd(1, 0);
    chk(EOB, 0);
    BAR_REPLACE <= 0;
    SHORT_BAR <= 0;
    apb(1, `BFL_OFS_CTRL, 32'h0000_0013);
    SHORT_BAR <= 1;
    w(2);
    chk(EOB, 1);
    BAR_REPLACE <= 1;
    lathe.cmd(1, 0);
    chk(EOB, 1);
    lathe.cmd(1, 0);
    chk(EOB, 0);
    apb(1, `BFL_OFS_CTRL, 32'h0000_0031);
    COVER_OPEN <= 1;
    w(3);
    chk(TEST_RUN, 0);
    COVER_OPEN <= 0;
    w(3);
    chk(TEST_RUN, 1);
    summarize;
  end
  initial begin
    w(5000);
    n_fail++;
    summarize;
  end
endmodule
bind bfl_handshake bfl_assertions #(.ACK_CYCLES(ACK_CYCLES)) u_chk (
  .CLK(CLK), .RST(RST), .MCODE(MCODE), .ACT_DONE(ACT_DONE),
  .COVER_OPEN(COVER_OPEN), .MFIN(MFIN), .TEST_RUN(TEST_RUN),
  .ERR_CODE(ERR_CODE), .CHAN_OFS_MM(CHAN_OFS_MM));
